// *** verilog/mpc_map.vh ***
// Offsets, field positions and timing for the Manchester packet channel
//----------------------------------------------------------------------
// Functional notes
// - Buffer has 32-bit host, 16-bit serial port
// - Half-duplex splits buffer; unidirectional uses all
// - Two selectable base bit rates
// - Transmit may use PLL; receive uses oscillator
// - Receiver oversamples line, recovers clock and data
// - Each line bit register or machine driven
// - Interrupt on transmit end, receive end
// - Per-source mask plus master interrupt enable
// - Machine status readable at any time
// - Every host read takes one wait state; writes take none
// - Control and I/O registers read-write, receive length read-only, all long-word aligned
// - 16-bit words sent back to back
// - First two buffer words are control words
// - Data word feeds shifter and CRC
// - CRC sent, then optional post amble, then next packet decided
// - Optional software CRC and post amble
// - Capture after idle plus four zeros
// - Free-running receive shifter, words to buffer
// - Embedded length locates received CRC
// - CRC mismatch sets CRC error bit
// - Coding violation in length, data or CRC aborts, sets Manchester error
// - Post amble checked, error bit on violation
//----------------------------------------------------------------------
`ifndef MPC_MAP_VH
`define MPC_MAP_VH
`define MPC_CLK_HZ      20000000
`define MPC_RATE_HI_HZ  5000000
`define MPC_RATE_LO_HZ  400000
`define MPC_HALF_HI     (`MPC_CLK_HZ / (2 * `MPC_RATE_HI_HZ))
`define MPC_HALF_LO     (`MPC_CLK_HZ / (2 * `MPC_RATE_LO_HZ))
`define MPC_A_CTRL      12'h000
`define MPC_A_STAT      12'h004
`define MPC_A_IOD       12'h008
`define MPC_A_IOS       12'h00C
`define MPC_A_RXLEN     12'h010
`define MPC_BUF_BIT     11
`define MPC_C_TXEN      0
`define MPC_C_RXEN      1
`define MPC_C_HALF      2
`define MPC_C_FAST      3
`define MPC_C_PLL       4
`define MPC_C_MEN       5
`define MPC_C_TXIE      6
`define MPC_C_RXIE      7
`define MPC_C_POSTCHK   8
`define MPC_CTRL_RST    9'h000
`define MPC_S_TXD       2
`define MPC_S_POSTE     6
`define MPC_F_SWCRC     0
`define MPC_F_POST      1
`define MPC_F_MORE      2
`define MPC_SYNC_ZEROS  5'h04
`endif

// *** verilog/mpc_channel.v ***
// One Manchester packet channel: buffer, framer, receiver, registers
`timescale 1ns/10ps
`include "mpc_map.vh"
module mpc_channel #(
    parameter          AW        = 9,
    parameter [15:0]   CRC_POLY  = 16'h1021,
    parameter [15:0]   CRC_SEED  = 16'hFFFF,
    parameter [0:0]    MAN_POL   = 1'b0,
    parameter          IDLE_BITS = 8,
    parameter          POST_BITS = 8,
    parameter [15:0]   POST_PAT  = 16'h00A5
) (
    // Clock and reset
    input  wire        clk,
    input  wire        rst_n,
    // Register port
    input  wire [11:0] reg_addr,
    input  wire [31:0] reg_wdata,
    input  wire        reg_wr,
    input  wire        reg_rd,
    output reg  [31:0] reg_rdata,
    // Serial line
    input  wire        ser_in,
    output reg         ser_out,
    output reg         ser_oe,
    // Transmit PLL clock pin
    input  wire        pll_clk,
    // Interrupt
    output reg         irq
);
    //------------------------------------------------------------------
    // Constants
    //------------------------------------------------------------------
    // Integer forms, cut to their register widths below
    localparam integer HHI_I   = `MPC_HALF_HI;
    localparam integer HLO_I   = `MPC_HALF_LO;
    localparam integer IHB_I   = 2 * IDLE_BITS;
    localparam integer PNB_I   = POST_BITS;
    localparam [4:0]  HALF_HI  = HHI_I[4:0];
    localparam [4:0]  HALF_LO  = HLO_I[4:0];
    localparam [0:0]  IDLE_LVL = ~MAN_POL;
    localparam [11:0] IDLE_HB  = IHB_I[11:0];
    localparam [7:0]  GAP_HT   = IHB_I[7:0];
    localparam [4:0]  POST_NB  = PNB_I[4:0];
    localparam [15:0] POST_MSK = ~(16'hFFFF << POST_BITS);
    localparam [15:0] POST_SH  = POST_PAT << (16 - POST_BITS);
    localparam [AW-1:0] ONE_A  = {{(AW-1){1'b0}}, 1'b1};
    localparam [2:0] TS_IDLE = 3'h0, TS_C0 = 3'h1, TS_C1 = 3'h2,
                     TS_C2 = 3'h3, TS_GAP = 3'h4, TS_SHIFT = 3'h5,
                     TS_END = 3'h6;
    localparam [2:0] K_SYNC = 3'h0, K_LEN = 3'h1, K_DATA = 3'h2,
                     K_CRC = 3'h3, K_POST = 3'h4;
    localparam [2:0] RS_HUNT = 3'h0, RS_SYNC = 3'h1, RS_LEN = 3'h2,
                     RS_DATA = 3'h3, RS_CRC = 3'h4, RS_POST = 3'h5;

    // Serial CRC over one word, MSB first
    function [15:0] crc_word;
        input [15:0] c;
        input [15:0] w;
        integer      i;
        reg   [15:0] r;
        begin
            r = c;
            for (i = 15; i >= 0; i = i - 1) begin
                if (r[15] ^ w[i])
                    r = {r[14:0], 1'b0} ^ CRC_POLY;
                else
                    r = {r[14:0], 1'b0};
            end
            crc_word = r;
        end
    endfunction

    //------------------------------------------------------------------
    // Registers and channel buffer
    //------------------------------------------------------------------
    reg [15:0]   buf_lo [0:(1<<(AW-1))-1];
    reg [15:0]   buf_hi [0:(1<<(AW-1))-1];
    reg [8:0]    ctrl_reg;
    reg [1:0]    iod_reg;
    reg [1:0]    ios_reg;
    reg [4:0]    flag_reg;
    reg          txen_d_reg;
    reg [2:0]    rxs_reg;
    reg [2:0]    pls_reg;
    reg          line_reg;
    reg          pll_lvl_reg;
    reg [4:0]    div_reg;
    reg          osc_tick_reg;
    reg [2:0]    ts_reg;
    reg [2:0]    tk_reg;
    reg [AW-1:0] toff_reg;
    reg [15:0]   tlen_reg;
    reg [15:0]   tcnt_reg;
    reg [2:0]    tflg_reg;
    reg [7:0]    gcnt_reg;
    reg [15:0]   tsh_reg;
    reg [4:0]    tnb_reg;
    reg          tph_reg;
    reg          tline_reg;
    reg [15:0]   tcrc_reg;
    reg [2:0]    rs_reg;
    reg          rprev_reg;
    reg [11:0]   rcnt_reg;
    reg          ridle_reg;
    reg [15:0]   rsh_reg;
    reg [4:0]    rbc_reg;
    reg [AW-1:0] roff_reg;
    reg [15:0]   rlen_reg;
    reg [15:0]   rrem_reg;
    reg [15:0]   rcrc_reg;
    reg          rwe_reg;
    reg [AW-1:0] rwa_reg;
    reg [15:0]   rwd_reg;
    reg [4:1]    ev_reg;
    reg          ev_tx_reg;

    wire              half    = ctrl_reg[`MPC_C_HALF];
    wire              in_buf  = reg_addr[`MPC_BUF_BIT];
    wire [AW-2:0]     hidx    = reg_addr[AW:2];
    wire              hwr_buf = reg_wr & in_buf;
    wire [4:0]        half_len = ctrl_reg[`MPC_C_FAST] ? HALF_HI : HALF_LO;
    wire [AW-1:0]     taddr = half ? {1'b0, toff_reg[AW-2:0]} : toff_reg;
    wire [AW-1:0]     raddr = half ? {1'b1, roff_reg[AW-2:0]} : roff_reg;
    wire [15:0]       s_rd  = taddr[0] ? buf_hi[taddr[AW-1:1]]
                                       : buf_lo[taddr[AW-1:1]];
    wire              pll_tick = (pls_reg[1] == pls_reg[2]) & pls_reg[2]
                                 & ~pll_lvl_reg;
    wire              tick = ctrl_reg[`MPC_C_PLL] ? pll_tick
                                                  : osc_tick_reg;
    wire              tbit  = tsh_reg[15];
    wire [11:0]       h12   = {7'h00, half_len};
    wire [11:0]       t_mid = h12 + {1'b0, h12[11:1]}; // 1.5 half-bits
    wire [11:0]       t_vio = {h12[9:0], 2'b00} + h12;
    wire [11:0]       t_idl = IDLE_HB * h12;
    wire              redge = line_reg ^ rprev_reg;
    wire              rmid  = redge & ((rcnt_reg >= t_mid) | ridle_reg);
    wire              rviol = ~redge & (rcnt_reg == t_vio);
    wire              rbit  = line_reg ^ MAN_POL;
    wire [15:0]       rword = {rsh_reg[14:0], rbit};
    wire              rpkt  = (rs_reg == RS_LEN) | (rs_reg == RS_DATA)
                              | (rs_reg == RS_CRC);
    wire [4:0]        ev_all = {ev_reg, ev_tx_reg};

    // Buffer banks: host 32-bit word, serial 16-bit half by address LSB
    always @(posedge clk) begin
        if (hwr_buf)
            buf_lo[hidx] <= reg_wdata[15:0];
        else if (rwe_reg && !rwa_reg[0])
            buf_lo[rwa_reg[AW-1:1]] <= rwd_reg;
    end

    always @(posedge clk) begin
        if (hwr_buf)
            buf_hi[hidx] <= reg_wdata[31:16];
        else if (rwe_reg && rwa_reg[0])
            buf_hi[rwa_reg[AW-1:1]] <= rwd_reg;
    end

    //------------------------------------------------------------------
    // Host register port
    //------------------------------------------------------------------
    // Writes to control registers, data back in next cycle only
    always @(posedge clk) begin
        if (!rst_n) begin
            ctrl_reg  <= `MPC_CTRL_RST;
            iod_reg   <= 2'h0;
            ios_reg   <= 2'h0;
            reg_rdata <= 32'h00000000;
        end else begin
            if (reg_wr && !in_buf) begin
                case (reg_addr)
                    `MPC_A_CTRL: ctrl_reg <= reg_wdata[8:0];
                    `MPC_A_IOD:  iod_reg  <= reg_wdata[1:0];
                    `MPC_A_IOS:  ios_reg  <= reg_wdata[1:0];
                    default:     ;
                endcase
            end
            reg_rdata <= 32'h00000000;
            if (reg_rd) begin
                if (in_buf)
                    reg_rdata <= {buf_hi[hidx], buf_lo[hidx]};
                else begin
                    case (reg_addr)
                        `MPC_A_CTRL: reg_rdata <= {23'h000000, ctrl_reg};
                        `MPC_A_STAT: reg_rdata <= {24'h000000, line_reg,
                                     flag_reg, rs_reg != RS_HUNT,
                                     ts_reg != TS_IDLE};
                        `MPC_A_IOD:  reg_rdata <= {30'h00000000, iod_reg};
                        `MPC_A_IOS:  reg_rdata <= {30'h00000000, ios_reg};
                        `MPC_A_RXLEN: reg_rdata <= {rlen_reg[15:0],
                                     {(16-AW){1'b0}}, roff_reg};
                        default:     reg_rdata <= 32'h00000000;
                    endcase
                end
            end
        end
    end

    // Sticky status, set wins over write-one clear
    always @(posedge clk) begin
        if (!rst_n) begin
            flag_reg <= 5'h00;
            irq      <= 1'b0;
        end else begin
            if (reg_wr && !in_buf && reg_addr == `MPC_A_STAT)
                flag_reg <= (flag_reg & ~reg_wdata[6:2]) | ev_all;
            else
                flag_reg <= flag_reg | ev_all;
            irq <= ctrl_reg[`MPC_C_MEN] &
                   ((flag_reg[0] & ctrl_reg[`MPC_C_TXIE]) |
                    (flag_reg[1] & ctrl_reg[`MPC_C_RXIE]));
        end
    end

    //------------------------------------------------------------------
    // Pin synchronisers and rate divider
    //------------------------------------------------------------------
    always @(posedge clk) begin
        if (!rst_n) begin
            rxs_reg      <= 3'h7;
            pls_reg      <= 3'h0;
            line_reg     <= 1'b1;
            pll_lvl_reg  <= 1'b0;
            div_reg      <= 5'h00;
            osc_tick_reg <= 1'b0;
        end else begin
            rxs_reg <= {rxs_reg[1:0], ser_in};
            pls_reg <= {pls_reg[1:0], pll_clk};
            if (rxs_reg[1] == rxs_reg[2])
                line_reg <= rxs_reg[2];
            if (pls_reg[1] == pls_reg[2])
                pll_lvl_reg <= pls_reg[2];
            if (div_reg >= half_len - 5'h01) begin
                div_reg      <= 5'h00;
                osc_tick_reg <= 1'b1;
            end else begin
                div_reg      <= div_reg + 5'h01;
                osc_tick_reg <= 1'b0;
            end
        end
    end

    //------------------------------------------------------------------
    // Transmitter
    //------------------------------------------------------------------
    always @(posedge clk) begin
        if (!rst_n) begin
            ts_reg <= TS_IDLE;
            tk_reg <= K_SYNC;
            toff_reg <= {AW{1'b0}};
            tlen_reg <= 16'h0000;
            tcnt_reg <= 16'h0000;
            tflg_reg <= 3'h0;
            gcnt_reg <= 8'h00;
            tsh_reg <= 16'h0000;
            tnb_reg <= 5'h00;
            tph_reg <= 1'b0;
            tline_reg <= IDLE_LVL;
            tcrc_reg <= CRC_SEED;
            txen_d_reg <= 1'b0;
            ev_tx_reg <= 1'b0;
        end else begin
            txen_d_reg <= ctrl_reg[`MPC_C_TXEN];
            ev_tx_reg <= 1'b0;
            case (ts_reg)
                TS_IDLE: begin
                    tline_reg <= IDLE_LVL;
                    toff_reg  <= {AW{1'b0}};
                    if (ctrl_reg[`MPC_C_TXEN] && !txen_d_reg)
                        ts_reg <= TS_C0;
                end
                TS_C0: begin
                    tlen_reg <= s_rd;
                    tcnt_reg <= s_rd;
                    toff_reg <= toff_reg + ONE_A;
                    ts_reg   <= TS_C1;
                end
                TS_C1: begin
                    tflg_reg <= s_rd[2:0];
                    toff_reg <= toff_reg + ONE_A;
                    ts_reg   <= TS_C2;
                end
                TS_C2: begin
                    gcnt_reg <= GAP_HT;
                    ts_reg   <= TS_GAP;
                end
                TS_GAP: if (tick) begin
                    tline_reg <= IDLE_LVL;
                    if (gcnt_reg == 8'h01) begin
                        tsh_reg <= 16'h0000;
                        tnb_reg <= `MPC_SYNC_ZEROS;
                        tph_reg <= 1'b0;
                        tk_reg  <= K_SYNC;
                        ts_reg  <= TS_SHIFT;
                    end else
                        gcnt_reg <= gcnt_reg - 8'h01;
                end
                TS_SHIFT: if (tick) begin
                    tph_reg <= ~tph_reg;
                    if (!tph_reg)
                        tline_reg <= ~tbit ^ MAN_POL;
                    else begin
                        tline_reg <= tbit ^ MAN_POL;
                        tsh_reg <= {tsh_reg[14:0], 1'b0};
                        tnb_reg <= tnb_reg - 5'h01;
                        if (tnb_reg == 5'h01) begin
                            tnb_reg <= 5'h10;
                            case (tk_reg)
                                K_SYNC: begin
                                    tsh_reg  <= tlen_reg;
                                    tcrc_reg <= crc_word(CRC_SEED,
                                                         tlen_reg);
                                    tk_reg   <= K_LEN;
                                end
                                K_LEN, K_DATA: begin
                                    if (tcnt_reg != 16'h0000) begin
                                        tsh_reg  <= s_rd;
                                        tcrc_reg <= crc_word(tcrc_reg,
                                                             s_rd);
                                        toff_reg <= toff_reg + ONE_A;
                                        tcnt_reg <= tcnt_reg - 16'h0001;
                                        tk_reg   <= K_DATA;
                                    end else begin
                                        tk_reg <= K_CRC;
                                        if (tflg_reg[`MPC_F_SWCRC]) begin
                                            tsh_reg  <= s_rd;
                                            toff_reg <= toff_reg + ONE_A;
                                        end else
                                            tsh_reg <= tcrc_reg;
                                    end
                                end
                                K_CRC: begin
                                    if (tflg_reg[`MPC_F_POST]) begin
                                        tsh_reg <= POST_SH;
                                        tnb_reg <= POST_NB;
                                        tk_reg  <= K_POST;
                                    end else
                                        ts_reg <= TS_END;
                                end
                                default: ts_reg <= TS_END;
                            endcase
                        end
                    end
                end
                TS_END: if (tick) begin
                    tline_reg <= IDLE_LVL;
                    if (tflg_reg[`MPC_F_MORE])
                        ts_reg <= TS_C0;
                    else begin
                        ts_reg    <= TS_IDLE;
                        ev_tx_reg <= 1'b1;
                    end
                end
                default: ts_reg <= TS_IDLE;
            endcase
        end
    end

    // Line pins: each bit register driven or machine driven
    always @(posedge clk) begin
        if (!rst_n) begin
            ser_out <= IDLE_LVL;
            ser_oe  <= 1'b0;
        end else begin
            ser_out <= ios_reg[0] ? iod_reg[0] : tline_reg;
            ser_oe  <= ios_reg[1] ? iod_reg[1]
                                  : (ts_reg != TS_IDLE);
        end
    end

    //------------------------------------------------------------------
    // Receiver
    //------------------------------------------------------------------
    always @(posedge clk) begin
        if (!rst_n) begin
            rs_reg <= RS_HUNT;
            rprev_reg <= 1'b1;
            rcnt_reg <= 12'h000;
            ridle_reg <= 1'b0;
            rsh_reg <= 16'h0000;
            rbc_reg <= 5'h00;
            roff_reg <= {AW{1'b0}};
            rlen_reg <= 16'h0000;
            rrem_reg <= 16'h0000;
            rcrc_reg <= CRC_SEED;
            rwe_reg <= 1'b0;
            rwa_reg <= {AW{1'b0}};
            rwd_reg <= 16'h0000;
            ev_reg[4:1] <= 4'h0;
        end else begin
            rprev_reg <= line_reg;
            rwe_reg <= 1'b0;
            ev_reg[4:1] <= 4'h0;
            // Time since last mid-bit transition, oscillator based
            if (rmid)
                rcnt_reg <= 12'h000;
            else if (rcnt_reg != 12'hFFF)
                rcnt_reg <= rcnt_reg + 12'h001;
            if (rmid)
                ridle_reg <= 1'b0;
            else if (rcnt_reg >= t_idl && line_reg == IDLE_LVL)
                ridle_reg <= 1'b1;
            if (rmid)
                rsh_reg <= rword;
            if (!ctrl_reg[`MPC_C_RXEN])
                rs_reg <= RS_HUNT;
            else if (rviol && rpkt) begin
                rs_reg    <= RS_HUNT;
                ev_reg[3] <= 1'b1;
            end else if (rviol && rs_reg == RS_POST) begin
                rs_reg    <= RS_HUNT;
                ev_reg[4] <= 1'b1;
            end else if (rviol)
                rs_reg <= RS_HUNT;
            else if (rmid) begin
                rbc_reg <= rbc_reg + 5'h01;
                case (rs_reg)
                    RS_HUNT: begin
                        rbc_reg <= 5'h01;
                        if (ridle_reg && !rbit)
                            rs_reg <= RS_SYNC;
                    end
                    RS_SYNC: begin
                        if (rbit)
                            rs_reg <= RS_HUNT;
                        else if (rbc_reg == `MPC_SYNC_ZEROS - 5'h01) begin
                            rs_reg   <= RS_LEN;
                            rbc_reg  <= 5'h00;
                            roff_reg <= {AW{1'b0}};
                        end
                    end
                    RS_LEN, RS_DATA, RS_CRC: if (rbc_reg == 5'h0F) begin
                        rbc_reg  <= 5'h00;
                        rwe_reg  <= 1'b1;
                        rwa_reg  <= raddr;
                        rwd_reg  <= rword;
                        roff_reg <= roff_reg + ONE_A;
                        rcrc_reg <= crc_word(rs_reg == RS_LEN ? CRC_SEED
                                             : rcrc_reg, rword);
                        if (rs_reg == RS_LEN) begin
                            rlen_reg <= rword;
                            rrem_reg <= rword;
                            rs_reg   <= (rword == 16'h0000) ? RS_CRC
                                                            : RS_DATA;
                        end else if (rs_reg == RS_DATA) begin
                            rrem_reg <= rrem_reg - 16'h0001;
                            if (rrem_reg == 16'h0001)
                                rs_reg <= RS_CRC;
                        end else begin
                            ev_reg[2] <= (rword != rcrc_reg);
                            if (ctrl_reg[`MPC_C_POSTCHK])
                                rs_reg <= RS_POST;
                            else begin
                                rs_reg    <= RS_HUNT;
                                ev_reg[1] <= 1'b1;
                            end
                        end
                    end
                    RS_POST: if (rbc_reg == POST_NB - 5'h01) begin
                        ev_reg[4] <= |((rword ^ POST_PAT) & POST_MSK);
                        ev_reg[1] <= 1'b1;
                        rs_reg    <= RS_HUNT;
                    end
                    default: rs_reg <= RS_HUNT;
                endcase
            end
        end
    end
endmodule

// *** sim/mpc_channel_sva.sv ***
// Port checker for the Manchester packet channel
`timescale 1ns/10ps
module mpc_chk (
    // Control, line and interrupt
    input wire clk, rst_n, reg_wr, reg_rd, ser_in, ser_out, ser_oe,
    input wire pll_clk, irq,
    // Register data
    input wire [11:0] reg_addr,
    input wire [31:0] reg_wdata, reg_rdata
);
    reg [8:0] ctrl_q;
    reg [1:0] sel_q, dat_q;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // Shadows of the host-written registers
    always @(posedge clk) begin
        if (!rst_n) {ctrl_q, sel_q, dat_q} <= 13'h0000;
        else if (reg_wr) begin
            if (reg_addr == 12'h000) ctrl_q <= reg_wdata[8:0];
            if (reg_addr == 12'h008) dat_q <= reg_wdata[1:0];
            if (reg_addr == 12'h00C) sel_q <= reg_wdata[1:0];
        end
    end
    a_rdata_idle: assert property (
        !$past(reg_rd) |-> reg_rdata == 32'h0) else $error("rdata not 0");
    a_ctrl_back: assert property ($past(reg_rd && reg_addr == 12'h000)
        |-> reg_rdata == {23'h0, $past(ctrl_q)}) else $error("ctrl read");
    a_sel_back: assert property ($past(reg_rd && reg_addr == 12'h00C)
        |-> reg_rdata == {30'h0, $past(sel_q)}) else $error("io_sel read");
    a_hole_zero: assert property (
        $past(reg_rd && reg_addr > 12'h010 && reg_addr < 12'h800)
        |-> reg_rdata == 32'h0) else $error("unmapped read");
    a_out_manual: assert property (
        sel_q[0] && $past(sel_q[0]) && $stable(dat_q) |-> ser_out == dat_q[0])
        else $error("ser_out not manual");
    a_oe_manual: assert property (
        sel_q[1] && $past(sel_q[1]) && $stable(dat_q) |-> ser_oe == dat_q[1])
        else $error("ser_oe not manual");
    a_irq_cause: assert property (
        $rose(irq) |-> $past(ctrl_q[5] && (ctrl_q[6] || ctrl_q[7])))
        else $error("irq without enable");
    a_irq_masked: assert property (
        !ctrl_q[5] && !$past(ctrl_q[5]) |-> !irq) else $error("irq masked");
endmodule
bind mpc_channel mpc_chk u_chk (.clk(clk), .rst_n(rst_n), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .ser_in(ser_in), .ser_out(ser_out), .ser_oe(ser_oe),
    .pll_clk(pll_clk), .irq(irq), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));

// *** sim/mpc_line_model.sv ***
// Far-end equipment: echoes the line back, can jam it
`timescale 1ns/10ps
module mpc_line_model (
    input  wire ser_out,
    input  wire ser_oe,
    input  wire jam,
    output wire ser_in
);
    // Released line falls to the pull-up; jam kills every transition
    assign #7 ser_in = jam ? 1'b0 : (ser_oe ? ser_out : 1'b1);
endmodule

// *** sim/testbench.sv ***
// Self-checking bench for the Manchester packet channel
`timescale 1ns/10ps
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin \
    n_fail++; $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
module testbench;
    reg         clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0;
    reg         pll_clk = 0, jam = 0;
    reg  [11:0] reg_addr = 12'h000;
    reg  [31:0] reg_wdata = 32'h0, rd;
    reg  [15:0] crc;
    reg  [15:0] exp_q[$];
    wire [31:0] reg_rdata;
    wire        ser_in, ser_out, ser_oe, irq;
    integer     n_fail = 0, check_count = 0, seed = 621, cyc = 0, i;
    mpc_channel u_mpc_channel (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .ser_in(ser_in), .ser_out(ser_out),
        .ser_oe(ser_oe), .pll_clk(pll_clk), .irq(irq));
    mpc_line_model u_mpc_line_model (.ser_out(ser_out), .ser_oe(ser_oe),
        .jam(jam), .ser_in(ser_in));
    // Clocks
    initial forever #25 clk = ~clk;
    always #37 pll_clk = ~pll_clk;
    // Bus cycles
    task wr(input [11:0] a, input [31:0] d);
        begin
            @(posedge clk);
            reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1;
            @(posedge clk);
            reg_wr <= 1'b0;
        end
    endtask
    task rdr(input [11:0] a);
        begin
            @(posedge clk);
            reg_addr <= a; reg_rd <= 1'b1;
            @(posedge clk);
            reg_rd <= 1'b0;
            #1 rd = reg_rdata;
        end
    endtask
    // Reference CRC, MSB first
    function [15:0] crc_step(input [15:0] c, input [15:0] w);
        integer k;
        begin
            crc_step = c;
            for (k = 15; k >= 0; k--) crc_step = {crc_step[14:0], 1'b0}
                ^ ((crc_step[15] ^ w[k]) ? 16'h1021 : 16'h0000);
        end
    endfunction
    // Restart the transmitter, optionally jam, poll status
    task send(input integer jam_at, input [31:0] m, input [8:0] c);
        begin
            wr(12'h000, {23'h0, c});
            wr(12'h000, {23'h0, c | 9'h001});
            if (jam_at > 0) begin
                repeat (jam_at) @(posedge clk);
                jam <= 1'b1;
                repeat (40) @(posedge clk);
                jam <= 1'b0;
            end
            rd = 0;
            for (i = 0; i < 4000 && (rd & m) !== m; i++) rdr(12'h004);
        end
    endtask
    task end_of_test;
        begin
            $display("checks %0d mismatches %0d", check_count, n_fail);
            if (n_fail == 0 && check_count > 0) $display("Regression OK");
            else $display("Regression broken");
            $finish;
        end
    endtask
    // Hang guard
    always @(posedge clk) begin
        cyc = cyc + 1;
        if (cyc == 20000) begin n_fail++; end_of_test; end
    end
    // Main sequence
    initial begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        rdr(12'h000); `CHK("ctrl_rst", 32'h0, rd)
        wr(12'h0F0, $random(seed));
        rdr(12'h0F0); `CHK("hole", 32'h0, rd)
        wr(12'h00C, 32'h3);
        for (i = 0; i < 4; i++) begin
            wr(12'h008, i);
            repeat (2) @(posedge clk);
            #1 `CHK("io_pin", i[1:0], {ser_oe, ser_out})
        end
        rdr(12'h00C); `CHK("io_sel", 32'h3, rd)
        wr(12'h00C, 32'h0);
        exp_q = {16'h0002, 16'($random(seed)), 16'($random(seed))};
        crc = 16'hFFFF;
        foreach (exp_q[k]) crc = crc_step(crc, exp_q[k]);
        exp_q.push_back(crc);
        wr(12'h800, {16'h0000, exp_q[0]});
        wr(12'h804, {exp_q[2], exp_q[1]});
        rdr(12'h804); `CHK("tx_buf", {exp_q[2], exp_q[1]}, rd)
        send(0, 32'hC, 9'h0EE);
        `CHK("irq_on", 1'b1, irq)
        `CHK("status", 5'h03, rd[6:2])
        for (i = 0; i < 2; i++) begin
            rdr(12'(12'hA00 + 4 * i));
            `CHK("rx_word", {exp_q[2*i+1], exp_q[2*i]}, rd)
        end
        rdr(12'h010); `CHK("rx_len", 16'h0002, rd[31:16])
        wr(12'h004, 32'h7C);
        repeat (2) @(posedge clk);
        #1 `CHK("irq_off", 1'b0, irq)
        send(80, 32'h4, 9'h0EE);
        `CHK("man_err", 1'b1, rd[5])
        // Slow rate, post amble sent and checked
        wr(12'h004, 32'h7C);
        wr(12'h800, {16'h0002, exp_q[0]});
        send(0, 32'hC, 9'h1E6);
        `CHK("post_ok", 5'h03, rd[6:2])
        end_of_test;
    end
endmodule
